// ### hdl/lvbr_pkg.sv
package lvbr_pkg;

	// register byte offsets on the avalon slave
	localparam logic [3:0] LVBR_ADDR_CTRL = 4'h0;
	localparam logic [3:0] LVBR_ADDR_DIV = 4'h4;
	localparam logic [3:0] LVBR_ADDR_STAT = 4'h8;

	// control register field positions
	localparam int LVBR_CTRL_EN0 = 0;
	localparam int LVBR_CTRL_EN1 = 1;
	localparam int LVBR_CTRL_ROUTE = 2;
	localparam int LVBR_CTRL_WIDE0 = 4;
	localparam int LVBR_CTRL_WIDE1 = 5;
	localparam int LVBR_CTRL_MAPB = 6;
	localparam int LVBR_CTRL_HSINV = 7;
	localparam int LVBR_CTRL_VSINV = 8;
	localparam int LVBR_CTRL_DEINV = 9;
	localparam int LVBR_CTRL_REFRES = 10;
	localparam int LVBR_CTRL_W = 11;
	localparam logic [10:0] LVBR_CTRL_RST = 11'h000;

	// status register field positions
	localparam int LVBR_STAT_SEEN0 = 0;
	localparam int LVBR_STAT_SEEN1 = 1;
	localparam int LVBR_STAT_PHASE = 2;
	localparam int LVBR_STAT_FRAMES = 8;

	// link timing
	localparam int LVBR_REF_MHZ = 250;
	localparam int LVBR_SPLIT_PCLK_MHZ = 170;
	localparam int LVBR_SINGLE_PCLK_MHZ = 85;
	localparam logic [7:0] LVBR_DIV_RST = 8'h01;
	localparam logic [2:0] LVBR_SLOTS = 3'h7;
	localparam logic [6:0] LVBR_CLK_PATTERN = 7'h0F;
	localparam int LVBR_LANES = 4;
	localparam int LVBR_WORD_W = 28;

	// routing modes, in control register encoding order
	typedef enum logic [1:0] {
		LVBR_SINGLE,
		LVBR_SPLIT,
		LVBR_DUP,
		LVBR_INDEP
	} lvbr_route_e;

	typedef logic [27:0] lvbr_word_t;

endpackage

// ### hdl/lvbr_ser.sv
`timescale 1ns/1ps
`default_nettype none
module lvbr_ser
	import lvbr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	lvbr_ser_if.ser sif
);

	// lane levels for one slot; slot s of lane l sits at bit l*7+s
	function automatic logic [3:0] slot_bits(lvbr_word_t w, logic [2:0] s);
		logic [3:0] b;
		b = 4'h0;
		for (int l = 0; l < LVBR_LANES; l++) begin
			b[l] = w[l*7 + int'(s)];
		end
		return b;
	endfunction

	lvbr_word_t sh, next_sh;
	logic [2:0] slot, next_slot;
	logic [7:0] cnt, next_cnt;
	logic busy, next_busy;
	logic [3:0] lanes, next_lanes;
	logic clk_lane, next_clk_lane;

	////////////////////////////////////////////////////////////////////
	// slot sequencer: divider restarts on each load so both channels
	// loaded together stay slot aligned
	always_comb begin
		next_sh = sh;
		next_slot = slot;
		next_cnt = cnt;
		next_busy = busy;
		next_lanes = lanes;
		next_clk_lane = clk_lane;
		if (!sif.en) begin
			next_busy = 1'b0;
			next_lanes = 4'h0;
			next_clk_lane = 1'b0;
		end else if (sif.load) begin
			next_sh = sif.word;
			next_lanes = slot_bits(sif.word, 3'h0);
			next_clk_lane = LVBR_CLK_PATTERN[0];
			next_slot = 3'h1;
			next_cnt = sif.div;
			next_busy = 1'b1;
		end else if (busy) begin
			if (cnt != 8'h00) begin
				next_cnt = cnt - 8'h01;
			end else if (slot == LVBR_SLOTS) begin
				// word done; lines hold until the next load
				next_busy = 1'b0;
			end else begin
				next_lanes = slot_bits(sh, slot);
				next_clk_lane = LVBR_CLK_PATTERN[slot];
				next_slot = slot + 3'h1;
				next_cnt = sif.div;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sh <= '0;
			slot <= 3'h0;
			cnt <= 8'h00;
			busy <= 1'b0;
			lanes <= 4'h0;
			clk_lane <= 1'b0;
		end else begin
			sh <= next_sh;
			slot <= next_slot;
			cnt <= next_cnt;
			busy <= next_busy;
			lanes <= next_lanes;
			clk_lane <= next_clk_lane;
		end
	end

	assign sif.lanes = lanes;
	assign sif.clk_lane = clk_lane;

endmodule // lvbr_ser
`default_nettype wire

// ### hdl/lvbr_ser_if.sv
`timescale 1ns/1ps
`default_nettype none
// one output channel: parallel word in, serial lane levels back
interface lvbr_ser_if;
	import lvbr_pkg::*;
	logic en;
	logic load;
	lvbr_word_t word;
	logic [7:0] div;
	logic [3:0] lanes;
	logic clk_lane;

	modport ctrl(output en, output load, output word, output div,
		input lanes, input clk_lane);
	modport ser(input en, input load, input word, input div,
		output lanes, output clk_lane);
endinterface
`default_nettype wire

// ### hdl/lvbr_top.sv
`timescale 1ns/1ps
`default_nettype none
module lvbr_top
	import lvbr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic in0_pclk,
	input wire logic [23:0] in0_rgb,
	input wire logic in0_hsync,
	input wire logic in0_vsync,
	input wire logic in0_de,
	input wire logic in0_ctl,
	input wire logic in1_pclk,
	input wire logic [23:0] in1_rgb,
	input wire logic in1_hsync,
	input wire logic in1_vsync,
	input wire logic in1_de,
	input wire logic in1_ctl,
	output logic [3:0] ch0_data,
	output logic ch0_clk,
	output logic [3:0] ch1_data,
	output logic ch1_clk,
	output logic ref_res_sel
);

	// captured pixel word: {ctl, de, vsync, hsync, r, g, b}
	// apply the programmed sync polarities
	function automatic lvbr_word_t fix_pol(lvbr_word_t w,
		logic [10:0] c);
		lvbr_word_t o;
		o = w;
		o[24] = w[24] ^ c[LVBR_CTRL_HSINV];
		o[25] = w[25] ^ c[LVBR_CTRL_VSINV];
		o[26] = w[26] ^ c[LVBR_CTRL_DEINV];
		return o;
	endfunction

	// place a pixel on the four lanes, lane l slot s at bit l*7+s;
	// mapping a puts colour lsbs on lane 0, mapping b puts msbs there
	function automatic lvbr_word_t map_word(lvbr_word_t p, logic mapb,
		logic wide);
		logic [5:0] r6, g6, b6;
		logic [1:0] r2, g2, b2;
		logic [6:0] l0, l1, l2, l3;
		logic hi;
		hi = mapb | ~wide; // 18-bit colour sits msb aligned
		r6 = hi ? p[23:18] : p[21:16];
		g6 = hi ? p[15:10] : p[13:8];
		b6 = hi ? p[7:2] : p[5:0];
		r2 = hi ? p[17:16] : p[23:22];
		g2 = hi ? p[9:8] : p[15:14];
		b2 = hi ? p[1:0] : p[7:6];
		l0 = {g6[0], r6};
		l1 = {b6[1:0], g6[5:1]};
		l2 = {p[26], p[25], p[24], b6[5:2]};
		l3 = {p[27], b2, g2, r2};
		if (!wide) begin
			l3 = 7'h00;
		end
		return {l3, l2, l1, l0};
	endfunction

	// merge written bytes into a register value
	function automatic logic [31:0] merge_be(logic [31:0] old,
		logic [31:0] wd, logic [3:0] be);
		logic [31:0] o;
		o = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				o[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return o;
	endfunction

	////////////////////////////////////////////////////////////////////
	// input synchronisers: pins are in the pixel clock domain, so
	// data and clock go through the same two stages and stay aligned
	lvbr_word_t meta0, meta1, sync0, sync1;
	logic [1:0] pmeta, psync, plast;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta0 <= '0;
			meta1 <= '0;
			sync0 <= '0;
			sync1 <= '0;
			pmeta <= 2'h0;
			psync <= 2'h0;
			plast <= 2'h0;
		end else begin
			meta0 <= {in0_ctl, in0_de, in0_vsync, in0_hsync, in0_rgb};
			meta1 <= {in1_ctl, in1_de, in1_vsync, in1_hsync, in1_rgb};
			sync0 <= meta0;
			sync1 <= meta1;
			pmeta <= {in1_pclk, in0_pclk};
			psync <= pmeta;
			plast <= psync;
		end
	end

	logic [1:0] rise;
	lvbr_word_t pix0, pix1;
	assign rise = psync & ~plast;

	////////////////////////////////////////////////////////////////////
	// registers and datapath state
	logic [10:0] ctrl, next_ctrl;
	logic [7:0] div, next_div;
	logic wreq, next_wreq;
	logic [31:0] rdata, next_rdata;
	logic seen0, next_seen0;
	logic seen1, next_seen1;
	logic [7:0] frames, next_frames;
	logic last_vs, next_last_vs;
	logic phase, next_phase;
	lvbr_word_t held, next_held;
	logic load0, next_load0;
	logic load1, next_load1;
	lvbr_word_t word0, next_word0;
	lvbr_word_t word1, next_word1;
	logic [3:0] d0, next_d0;
	logic [3:0] d1, next_d1;
	logic c0, next_c0;
	logic c1, next_c1;

	// synced pixels with the programmed polarities applied
	assign pix0 = fix_pol(sync0, ctrl);
	assign pix1 = fix_pol(sync1, ctrl);

	lvbr_route_e route;
	logic en0, en1, mapb, wide0, wide1;
	logic access, req;
	logic [31:0] stat_word;
	assign route = lvbr_route_e'(ctrl[LVBR_CTRL_ROUTE +: 2]);
	assign en0 = ctrl[LVBR_CTRL_EN0];
	assign en1 = ctrl[LVBR_CTRL_EN1];
	assign mapb = ctrl[LVBR_CTRL_MAPB];
	assign wide0 = ctrl[LVBR_CTRL_WIDE0];
	assign wide1 = ctrl[LVBR_CTRL_WIDE1];
	assign req = avs_read | avs_write;
	assign access = req & ~wreq;
	assign stat_word = {16'h0000, frames, 5'h00, phase, seen1, seen0};

	lvbr_ser_if sif0();
	lvbr_ser_if sif1();

	// avalon slave: waitrequest drops one cycle after the request,
	// for one cycle; the write lands and read data stand at that edge
	always_comb begin
		next_wreq = ~(req & wreq);
		next_rdata = rdata;
		next_ctrl = ctrl;
		next_div = div;
		if (req & wreq & avs_read) begin
			case (avs_address)
				LVBR_ADDR_CTRL: next_rdata = {21'h0, ctrl};
				LVBR_ADDR_DIV: next_rdata = {24'h0, div};
				LVBR_ADDR_STAT: next_rdata = stat_word;
				default: next_rdata = 32'h0000_0000;
			endcase
		end
		if (access & avs_write) begin
			case (avs_address)
				LVBR_ADDR_CTRL: begin
					next_ctrl = 11'(merge_be({21'h0, ctrl}, avs_writedata,
						avs_byteenable));
				end
				LVBR_ADDR_DIV: begin
					next_div = 8'(merge_be({24'h0, div}, avs_writedata,
						avs_byteenable));
				end
				default: next_div = div; // unmapped writes are dropped
			endcase
		end
	end

	// status: seen flags clear on a status read, a new edge wins
	always_comb begin
		next_seen0 = seen0;
		next_seen1 = seen1;
		next_frames = frames;
		next_last_vs = last_vs;
		if (access & avs_read & (avs_address == LVBR_ADDR_STAT)) begin
			next_seen0 = 1'b0;
			next_seen1 = 1'b0;
		end
		if (rise[0]) begin
			next_seen0 = 1'b1;
			next_last_vs = pix0[25];
			if (pix0[25] & ~last_vs) begin
				next_frames = frames + 8'h01;
			end
		end
		if (rise[1]) begin
			next_seen1 = 1'b1;
		end
	end

	// routing: a load pulse per channel hands a mapped word to its
	// serialiser; in split mode the even pixel waits for its partner
	always_comb begin
		next_load0 = 1'b0;
		next_load1 = 1'b0;
		next_word0 = word0;
		next_word1 = word1;
		next_held = held;
		next_phase = phase;
		case (route)
			LVBR_SINGLE: begin
				next_phase = 1'b0;
				if (rise[0]) begin
					next_load0 = en0;
					next_word0 = map_word(pix0, mapb, wide0);
				end
			end
			LVBR_SPLIT: begin
				if (rise[0] & ~phase) begin
					next_held = pix0;
					next_phase = 1'b1;
				end else if (rise[0]) begin
					next_load0 = en0;
					next_load1 = en1;
					next_word0 = map_word(held, mapb, wide0);
					next_word1 = map_word(pix0, mapb, wide1);
					next_phase = 1'b0;
				end
				if (~(en0 & en1)) begin
					// a half-enabled link restarts pairing at channel zero
					next_phase = 1'b0;
				end
			end
			LVBR_DUP: begin
				next_phase = 1'b0;
				if (rise[0]) begin
					next_load0 = en0;
					next_load1 = en1;
					next_word0 = map_word(pix0, mapb, wide0);
					next_word1 = map_word(pix0, mapb, wide1);
				end
			end
			LVBR_INDEP: begin
				next_phase = 1'b0;
				if (rise[0]) begin
					next_load0 = en0;
					next_word0 = map_word(pix0, mapb, wide0);
				end
				if (rise[1]) begin
					next_load1 = en1;
					next_word1 = map_word(pix1, mapb, wide1);
				end
			end
			default: next_phase = 1'b0;
		endcase
	end

	// output stage: one flop between serialiser and pins
	always_comb begin
		next_d0 = sif0.lanes;
		next_d1 = sif1.lanes;
		next_c0 = sif0.clk_lane;
		next_c1 = sif1.clk_lane;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= LVBR_CTRL_RST;
			div <= LVBR_DIV_RST;
			wreq <= 1'b1;
			rdata <= 32'h0000_0000;
			seen0 <= 1'b0;
			seen1 <= 1'b0;
			frames <= 8'h00;
			last_vs <= 1'b0;
			phase <= 1'b0;
			held <= '0;
			load0 <= 1'b0;
			load1 <= 1'b0;
			word0 <= '0;
			word1 <= '0;
			d0 <= 4'h0;
			d1 <= 4'h0;
			c0 <= 1'b0;
			c1 <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			div <= next_div;
			wreq <= next_wreq;
			rdata <= next_rdata;
			seen0 <= next_seen0;
			seen1 <= next_seen1;
			frames <= next_frames;
			last_vs <= next_last_vs;
			phase <= next_phase;
			held <= next_held;
			load0 <= next_load0;
			load1 <= next_load1;
			word0 <= next_word0;
			word1 <= next_word1;
			d0 <= next_d0;
			d1 <= next_d1;
			c0 <= next_c0;
			c1 <= next_c1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// serialisers; the slot divider limits the pixel rate at this
	// reference clock, so a pixel faster than 7*(div+1) cycles truncates
	assign sif0.en = en0;
	assign sif0.load = load0;
	assign sif0.word = word0;
	assign sif0.div = div;
	assign sif1.en = en1;
	assign sif1.load = load1;
	assign sif1.word = word1;
	assign sif1.div = div;

	lvbr_ser u_ser0 (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.sif(sif0.ser)
	);

	lvbr_ser u_ser1 (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.sif(sif1.ser)
	);

	assign avs_readdata = rdata;
	assign avs_waitrequest = wreq;
	assign ch0_data = d0;
	assign ch0_clk = c0;
	assign ch1_data = d1;
	assign ch1_clk = c1;
	assign ref_res_sel = ctrl[LVBR_CTRL_REFRES];

endmodule // lvbr_top
`default_nettype wire

// ### verification/lvbr_panel.sv
`timescale 1ns/1ps
`default_nettype none
// receiving end of one channel: rebuilds each word from its slots
module lvbr_panel
	import lvbr_pkg::*;
#(
	parameter int SLOT = 2
)
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [3:0] lanes,
	input wire logic clk_lane,
	output var lvbr_word_t word,
	output logic [6:0] cpat,
	output logic [15:0] cnt
);
	int t;
	logic prev;
	lvbr_word_t acc;
	logic [6:0] cacc;
	// a rising clock pair marks slot 0; a new rise restarts the word
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			t = 99;
			prev = 1'b0;
			cnt = 16'h0000;
			word = '0;
			cpat = 7'h00;
		end else begin
			if (clk_lane && !prev) begin
				t = 0;
			end
			if (t % SLOT == 0 && t < 7 * SLOT) begin
				for (int l = 0; l < 4; l++) begin
					acc[l * 7 + t / SLOT] = lanes[l];
				end
				cacc[t / SLOT] = clk_lane;
				if (t == 6 * SLOT) begin
					word = acc;
					cpat = cacc;
					cnt = cnt + 16'h0001;
				end
			end
			t = (t < 99) ? t + 1 : t;
			prev = clk_lane;
		end
	end
endmodule // lvbr_panel
`default_nettype wire

// ### verification/lvbr_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module lvbr_top_asserts
	import lvbr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [3:0] ch0_data,
	input wire logic ch0_clk,
	input wire logic [3:0] ch1_data,
	input wire logic ch1_clk,
	input wire logic ref_res_sel
);
	logic [10:0] cfg, next_cfg;
	logic [7:0] div, next_div, hi, next_hi;
	logic [3:0] age, next_age;
	logic wacc, st, both, unm;
	////////////////////////////////////////////////////////////////
	// shadow of control and divider; age gives the outputs eight
	// cycles to follow a mode change before mode checks apply
	always_comb begin
		wacc = avs_write && !avs_waitrequest;
		unm = !(avs_address inside {LVBR_ADDR_CTRL, LVBR_ADDR_DIV,
			LVBR_ADDR_STAT});
		next_cfg = cfg;
		next_div = div;
		next_age = age[3] ? age : age + 4'h1;
		next_hi = ch0_clk ? hi + 8'h01 : 8'h00;
		if (wacc && avs_address == LVBR_ADDR_CTRL) begin
			next_cfg = avs_writedata[10:0];
			next_age = 4'h0;
		end
		if (wacc && avs_address == LVBR_ADDR_DIV) begin
			next_div = avs_writedata[7:0];
		end
		st = age[3];
		both = st && cfg[1:0] == 2'b11;
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg <= LVBR_CTRL_RST;
			div <= LVBR_DIV_RST;
			hi <= 8'h00;
			age <= 4'h0;
		end else begin
			cfg <= next_cfg;
			div <= next_div;
			hi <= next_hi;
			age <= next_age;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ans;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	bus_answer_a: assert property (s_req |=> s_ans)
		else $error("bus answer late or too long");
	unmapped_read_a: assert property ((avs_read || avs_write)
		&& avs_waitrequest && avs_read && unm
		|=> avs_readdata == 32'h0) else $error("unmapped read not zero");
	ref_res_a: assert property (wacc && !unm && avs_address == 4'h0
		|=> ref_res_sel == cfg[LVBR_CTRL_REFRES]) else $error("ref pin");
	clk_high_a: assert property ($fell(ch0_clk)
		|-> int'(hi) == 4 * (int'(div) + 1)) else $error("clock pair width");
	quiet_ch0_a: assert property (!cfg[0] && st
		|-> ch0_data == 4'h0 && !ch0_clk) else $error("ch0 not quiet");
	quiet_ch1_a: assert property (!cfg[1] && st
		|-> ch1_data == 4'h0 && !ch1_clk) else $error("ch1 not quiet");
	narrow_lane_a: assert property (cfg[0] && !cfg[4] && st
		|-> !ch0_data[3]) else $error("fourth pair busy at 18 bit");
	dup_same_a: assert property (both && cfg[3:2] == LVBR_DUP
		|-> ch0_data == ch1_data && ch0_clk == ch1_clk)
		else $error("duplicate channels differ");
	split_clk_a: assert property (both && cfg[3:2] == LVBR_SPLIT
		&& $rose(ch0_clk) |-> $rose(ch1_clk)) else $error("split skew");
endmodule // lvbr_top_asserts
bind lvbr_top lvbr_top_asserts u_chk (.ref_clk, .arst_n, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
	.ch0_data, .ch0_clk, .ch1_data, .ch1_clk, .ref_res_sel);
`default_nettype wire

// ### verification/lvbr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lvbr_top_tb
	import lvbr_pkg::*;
;
	logic ref_clk, arst_n, avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_address, avs_byteenable, ch0_data, ch1_data;
	logic [31:0] avs_writedata, avs_readdata, rdv;
	logic in0_pclk, in0_hsync, in0_vsync, in0_de, in0_ctl;
	logic in1_pclk, in1_hsync, in1_vsync, in1_de, in1_ctl;
	logic [23:0] in0_rgb, in1_rgb;
	logic ch0_clk, ch1_clk, ref_res_sel;
	lvbr_word_t w0, w1, e;
	logic [6:0] p0, p1;
	logic [15:0] n0, n1, m0, m1;
	int fail_count, num_checks;
	lvbr_top dut (.ref_clk, .arst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.in0_pclk, .in0_rgb, .in0_hsync, .in0_vsync, .in0_de, .in0_ctl,
		.in1_pclk, .in1_rgb, .in1_hsync, .in1_vsync, .in1_de, .in1_ctl,
		.ch0_data, .ch0_clk, .ch1_data, .ch1_clk, .ref_res_sel);
	// divider stays at its reset value, so each slot lasts two cycles
	lvbr_panel #(.SLOT(2)) pan0 (.ref_clk, .arst_n, .lanes(ch0_data),
		.clk_lane(ch0_clk), .word(w0), .cpat(p0), .cnt(n0));
	lvbr_panel #(.SLOT(2)) pan1 (.ref_clk, .arst_n, .lanes(ch1_data),
		.clk_lane(ch1_clk), .word(w1), .cpat(p1), .cnt(n1));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			$display("BAD %s expected %h seen %h", nm, x, g);
			fail_count++;
		end
	endtask
	// one bus access, held until waitrequest is sampled low
	task automatic bus(input logic [3:0] a, input logic w,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		rdv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 40) begin
			fail_count++;
			close_out();
		end
	endtask
	// modes go in with both channels off; enables come last
	task automatic setup(input logic [10:0] c);
		bus(LVBR_ADDR_CTRL, 1'b1, 32'h0);
		bus(LVBR_ADDR_CTRL, 1'b1, {21'h0, c & 11'h7FC});
		bus(LVBR_ADDR_CTRL, 1'b1, {21'h0, c});
		cyc(10);
	endtask
	// s is {ctl, de, vsync, hsync}; 18 bit and mapping b use [7:2]
	function automatic lvbr_word_t exp_w(input logic [23:0] c,
		input logic [3:0] s, input logic w, input logic b);
		logic m;
		logic [5:0] r, g, u, h;
		m = b || !w;
		r = m ? c[23:18] : c[21:16];
		g = m ? c[15:10] : c[13:8];
		u = m ? c[7:2] : c[5:0];
		h = m ? {c[1:0], c[9:8], c[17:16]} : {c[7:6], c[15:14], c[23:22]};
		exp_w = {s[3], h, s[2:0], u, g, r};
		if (!w) begin
			exp_w[27:21] = 7'h00;
		end
	endfunction
	// one pixel on both inputs, 80 ns pixel period; the panel has the
	// word one cycle before this returns, and pclk rests low after it
	task automatic pix(input logic [23:0] a, input logic [3:0] sa,
		input logic [23:0] b, input logic [3:0] sb);
		in0_rgb <= a;
		{in0_ctl, in0_de, in0_vsync, in0_hsync} <= sa;
		in1_rgb <= b;
		{in1_ctl, in1_de, in1_vsync, in1_hsync} <= sb;
		cyc(1);
		{in0_pclk, in1_pclk} <= 2'b11;
		cyc(10);
		{in0_pclk, in1_pclk} <= 2'b00;
		cyc(9);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		bus(LVBR_ADDR_CTRL, 1'b0, 32'h0);
		chk("ctrl", 32'h0, rdv);
		bus(LVBR_ADDR_DIV, 1'b0, 32'h0);
		chk("div", 32'h1, rdv);
		bus(4'hC, 1'b1, 32'hFFFFFFFF);
		bus(4'hC, 1'b0, 32'h0);
		chk("unmapped", 32'h0, rdv);
		bus(LVBR_ADDR_CTRL, 1'b1, 32'h400);
		cyc(1);
		chk("ref_res", 32'h1, {31'h0, ref_res_sel});
		$display("regs done");
	endtask
	task automatic t_single();
		setup(11'h011);
		m1 = n1;
		pix(24'hA5C33C, 4'hB, 24'h5A5A5A, 4'hF);
		e = exp_w(24'hA5C33C, 4'hB, 1'b1, 1'b0);
		chk("w0", 32'(e), 32'(w0));
		chk("p0", 32'h0F, 32'(p0));
		chk("n1", 32'(m1), 32'(n1));
		$display("single done");
	endtask
	task automatic t_narrow();
		setup(11'h001);
		pix(24'h5AF00F, 4'hF, 24'h0, 4'h0);
		e = exp_w(24'h5AF00F, 4'hF, 1'b0, 1'b0);
		chk("w0", 32'(e), 32'(w0));
		$display("narrow done");
	endtask
	task automatic t_mapb();
		setup(11'h3D1);
		pix(24'h3C96E1, 4'h6, 24'h0, 4'h0);
		e = exp_w(24'h3C96E1, 4'h1, 1'b1, 1'b1);
		chk("w0", 32'(e), 32'(w0));
		$display("mapb done");
	endtask
	task automatic t_dup();
		setup(11'h03B);
		pix(24'h123456, 4'h5, 24'hFEDCBA, 4'hA);
		e = exp_w(24'h123456, 4'h5, 1'b1, 1'b0);
		chk("w0", 32'(e), 32'(w0));
		chk("w1", 32'(e), 32'(w1));
		$display("dup done");
	endtask
	task automatic t_indep();
		setup(11'h01F);
		pix(24'h0F1E2D, 4'h3, 24'hC3A5F0, 4'hC);
		e = exp_w(24'h0F1E2D, 4'h3, 1'b1, 1'b0);
		chk("w0", 32'(e), 32'(w0));
		e = exp_w(24'hC3A5F0, 4'hC, 1'b0, 1'b0);
		chk("w1", 32'(e), 32'(w1));
		$display("indep done");
	endtask
	task automatic t_split();
		setup(11'h037);
		m0 = n0;
		m1 = n1;
		pix(24'h6B2D91, 4'h2, 24'h777777, 4'h1);
		chk("held0", 32'(m0), 32'(n0));
		chk("held1", 32'(m1), 32'(n1));
		// two vsync starts so far, both edges seen, even pixel held
		bus(LVBR_ADDR_STAT, 1'b0, 32'h0);
		chk("stat", 32'h0000_0207, rdv);
		pix(24'h9D4E27, 4'hD, 24'h777777, 4'h1);
		e = exp_w(24'h6B2D91, 4'h2, 1'b1, 1'b0);
		chk("w0", 32'(e), 32'(w0));
		e = exp_w(24'h9D4E27, 4'hD, 1'b1, 1'b0);
		chk("w1", 32'(e), 32'(w1));
		$display("split done");
	endtask
	initial begin
		fail_count = 0;
		num_checks = 0;
		arst_n = 1'b0;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hF;
		{in0_pclk, in0_hsync, in0_vsync, in0_de, in0_ctl, in0_rgb} = '0;
		{in1_pclk, in1_hsync, in1_vsync, in1_de, in1_ctl, in1_rgb} = '0;
		cyc(8);
		arst_n <= 1'b1;
		t_regs();
		t_single();
		t_narrow();
		t_mapb();
		t_dup();
		t_indep();
		t_split();
		close_out();
	end
endmodule // lvbr_top_tb
`default_nettype wire
